// ==== logic/ocs_regs.svh ====
// register offsets, reset values, field positions and timing counts for overcurrent sensing
// Contract
// R1: sample each enabled port's pin continuously
// R2: flag overcurrent on long enough low
// R3: flag overcurrent on two lows within window
// R4: min width field bits 3:0, 0-5 ms; code accepts 0-15 ms
// R5: min width resets to 5 ms
// R6: double-pulse window field bits 7:0
// R7: window in 1 ms steps, reset 20 ms
// R8: software never writes zero to window/lockout
// R9: ignore overcurrent during lockout after power-on
// R10: lockout in 1 ms steps, reset 10 ms
// R11: power off drives pin low
// R12: power on releases pin, enables pull-up
// R13: low while powered means overcurrent
// R14: one control/sense channel per port
// R15: poly fuse needs zero power-good descriptors
// R16: ganged overcurrent flags every port
// R17: individual mode after reset; code has no reset value for the mode and takes it from the gang_mode input
// R18: timers run on 1 ms tick
// R19: flag latched until cleared; paused while off
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

`define OCS_NUM_PORTS        6
`define OCS_NUM_CHAN         7
`define OCS_SHARED_CHAN      6
`define OCS_CLK_PERIOD_NS    10
`define OCS_TICK_TIME_NS     1000000
`define OCS_TICK_CYCLES      (`OCS_TICK_TIME_NS / `OCS_CLK_PERIOD_NS)

`define OCS_LOCKOUT_OFFSET   16'h30e1
`define OCS_MIN_WIDTH_OFFSET 16'h30ea
`define OCS_WINDOW_OFFSET    16'h30eb
`define OCS_STATUS_OFFSET    16'h30f0

`define OCS_LOCKOUT_RST      8'h0a
`define OCS_MIN_WIDTH_RST    4'h5
`define OCS_WINDOW_RST       8'h14
`define OCS_MIN_WIDTH_MSB    3

`endif

// ==== logic/ocs_pkg.sv ====
// types shared by the overcurrent sensing logic
package ocs_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [3:0] width_code_t;
   typedef enum logic [2:0] {
      ST_OFF   = 3'b001,
      ST_LOCK  = 3'b010,
      ST_WATCH = 3'b100
   } chan_state_t;
endpackage : ocs_pkg

// ==== logic/ocs_channel.sv ====
// one power-control and overcurrent-sense channel: lockout, single and double pulse detect
`timescale 1ns/1ps
module ocs_channel (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              tick,
   input  wire logic              power_en,
   input  wire logic              pin_low,
   input  wire ocs_pkg::width_code_t min_width,
   input  wire ocs_pkg::reg_byte_t window,
   input  wire ocs_pkg::reg_byte_t lockout,
   output logic                   ocs_event
);
   import ocs_pkg::*;

   chan_state_t state_ff;
   reg_byte_t   lock_cnt_ff;
   reg_byte_t   win_cnt_ff;
   logic [3:0]  low_cnt_ff;
   logic        low_prev_ff;
   logic        event_ff;
   logic        watching;
   logic        low_seen;
   logic        low_start;
   logic        single_hit;
   logic        double_hit;

   assign watching   = (state_ff == ST_WATCH);
   assign low_seen   = watching && pin_low;                      // [R1] [R13] [R19]
   assign low_start  = low_seen && !low_prev_ff;
   assign single_hit = low_seen && (low_cnt_ff >= min_width);    // [R2]
   assign double_hit = low_start && (win_cnt_ff != 8'h00);       // [R3]
   assign ocs_event  = event_ff;

   // lockout sequencing after power-on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= ST_OFF;
         lock_cnt_ff <= 8'h00;
      end else begin
         case (state_ff)
            ST_OFF: begin
               if (power_en) begin
                  state_ff    <= ST_LOCK;
                  lock_cnt_ff <= lockout;                        // [R9] [R18]
               end
            end
            ST_LOCK: begin
               if (!power_en) begin
                  state_ff <= ST_OFF;
               end else if (lock_cnt_ff == 8'h00) begin
                  state_ff <= ST_WATCH;
               end else if (tick) begin
                  lock_cnt_ff <= lock_cnt_ff - 8'h01;            // [R10]
               end
            end
            ST_WATCH: begin
               if (!power_en) begin
                  state_ff <= ST_OFF;
               end
            end
            default: begin
               state_ff <= ST_OFF;
            end
         endcase
      end
   end

   // consecutive low width in ms ticks, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_ff  <= 4'h0;
         low_prev_ff <= 1'b0;
      end else begin
         low_prev_ff <= low_seen;
         if (!low_seen) begin
            low_cnt_ff <= 4'h0;
         end else if (tick && (low_cnt_ff != 4'hf)) begin
            low_cnt_ff <= low_cnt_ff + 4'h1;                     // [R18]
         end
      end
   end

   // rolling window opened by the first low group
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_ff <= 8'h00;
      end else if (!watching) begin
         win_cnt_ff <= 8'h00;
      end else if (low_start && (win_cnt_ff == 8'h00)) begin
         win_cnt_ff <= window;                                   // [R6] [R7]
      end else if (tick && (win_cnt_ff != 8'h00)) begin
         win_cnt_ff <= win_cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         event_ff <= 1'b0;
      end else begin
         event_ff <= single_hit || double_hit;
      end
   end

   a_lockout_quiet : assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      (state_ff != ST_WATCH) |=> !event_ff)
      else $error("overcurrent event raised outside watch state");

   a_single_detect : assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      (watching && pin_low && (low_cnt_ff >= min_width)) |=> event_ff)
      else $error("long low pulse not flagged");

   a_double_detect : assert property (@(posedge clk) disable iff (!rst_n) // [R3]
      (low_seen && !low_prev_ff && (win_cnt_ff != 8'h00)) |=> event_ff)
      else $error("second low group inside window not flagged");

endmodule : ocs_channel

// ==== logic/port_overcurrent_detect.sv ====
// per-port power control and overcurrent detection with register access
`timescale 1ns/1ps
`include "ocs_regs.svh"
module port_overcurrent_detect #(
   parameter int unsigned TICK_CYCLES = `OCS_TICK_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic [`OCS_NUM_PORTS-1:0] port_power_en,
   input  wire logic                      gang_mode,
   input  wire logic [`OCS_NUM_PORTS-1:0] port_power_sense_pin_i,
   output logic      [`OCS_NUM_PORTS-1:0] port_power_sense_pin_o,
   output logic      [`OCS_NUM_PORTS-1:0] port_power_sense_pin_oe,
   output logic      [`OCS_NUM_PORTS-1:0] port_pullup_en,
   input  wire logic                      shared_power_sense_pin_i,
   output logic                           shared_power_sense_pin_o,
   output logic                           shared_power_sense_pin_oe,
   output logic                           shared_pullup_en,
   input  wire logic [15:0]               reg_addr,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   input  wire ocs_pkg::reg_byte_t        reg_wdata,
   output ocs_pkg::reg_byte_t             reg_rdata,
   output logic      [`OCS_NUM_PORTS-1:0] ocs_flag
);
   import ocs_pkg::*;

   // reset release synchroniser
   logic                       rst_meta_ff;
   logic                       rst_n_sync;

   logic [16:0]                tick_cnt_ff;
   logic                       tick_ff;

   logic [`OCS_NUM_CHAN-1:0]   pin_meta_ff;
   logic [`OCS_NUM_CHAN-1:0]   pin_sync_ff;
   logic [`OCS_NUM_CHAN-1:0]   chan_power;
   logic [`OCS_NUM_CHAN-1:0]   chan_event;
   logic [`OCS_NUM_CHAN-1:0]   drive_low_ff;
   logic [`OCS_NUM_CHAN-1:0]   pullup_ff;

   reg_byte_t                  lockout_ff;
   width_code_t                min_width_ff;
   reg_byte_t                  window_ff;
   logic [`OCS_NUM_PORTS-1:0]  flag_ff;
   logic [`OCS_NUM_PORTS-1:0]  flag_set;
   logic [`OCS_NUM_PORTS-1:0]  flag_clr;
   reg_byte_t                  rdata_ff;
   reg_byte_t                  nxt_rdata;

   logic                       gang_power;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_sync  <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_sync  <= rst_meta_ff;
      end
   end

   // 1 ms tick from the core clock
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         tick_cnt_ff <= 17'h00000;
         tick_ff     <= 1'b0;
      end else if (tick_cnt_ff == 17'(TICK_CYCLES - 1)) begin
         tick_cnt_ff <= 17'h00000;
         tick_ff     <= 1'b1;                                     // [R18]
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 17'h00001;
         tick_ff     <= 1'b0;
      end
   end

   // pins come from outside: two flops before use
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         pin_meta_ff <= {`OCS_NUM_CHAN{1'b1}};
         pin_sync_ff <= {`OCS_NUM_CHAN{1'b1}};
      end else begin
         pin_meta_ff <= {shared_power_sense_pin_i, port_power_sense_pin_i};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // ganged mode moves all power control onto the shared pin
   assign gang_power = gang_mode && (|port_power_en);
   assign chan_power = {gang_power, port_power_en & {`OCS_NUM_PORTS{~gang_mode}}}; // [R17]

   genvar gi;
   generate
      for (gi = 0; gi < `OCS_NUM_CHAN; gi++) begin : g_chan
         ocs_channel u_chan (                                      // [R14]
            .clk       (clk),
            .rst_n     (rst_n_sync),
            .tick      (tick_ff),
            .power_en  (chan_power[gi]),
            .pin_low   (~pin_sync_ff[gi]),                         // [R13]
            .min_width (min_width_ff),
            .window    (window_ff),
            .lockout   (lockout_ff),
            .ocs_event (chan_event[gi])
         );
      end
   endgenerate

   // pin drive: low while off, released with pull-up while on
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         drive_low_ff <= {`OCS_NUM_CHAN{1'b1}};
         pullup_ff    <= {`OCS_NUM_CHAN{1'b0}};
      end else begin
         drive_low_ff <= ~chan_power;                             // [R11]
         pullup_ff    <= chan_power;                              // [R12]
      end
   end

   assign port_power_sense_pin_o    = {`OCS_NUM_PORTS{1'b0}};
   assign port_power_sense_pin_oe   = drive_low_ff[`OCS_NUM_PORTS-1:0];
   assign port_pullup_en            = pullup_ff[`OCS_NUM_PORTS-1:0];
   assign shared_power_sense_pin_o  = 1'b0;
   assign shared_power_sense_pin_oe = drive_low_ff[`OCS_SHARED_CHAN];
   assign shared_pullup_en          = pullup_ff[`OCS_SHARED_CHAN];

   // timing registers
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         lockout_ff <= `OCS_LOCKOUT_RST;                          // [R10]
      end else if (reg_wr && (reg_addr == `OCS_LOCKOUT_OFFSET)) begin
         lockout_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         min_width_ff <= `OCS_MIN_WIDTH_RST;                      // [R5]
      end else if (reg_wr && (reg_addr == `OCS_MIN_WIDTH_OFFSET)) begin
         min_width_ff <= reg_wdata[`OCS_MIN_WIDTH_MSB:0];         // [R4]
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         window_ff <= `OCS_WINDOW_RST;                            // [R7]
      end else if (reg_wr && (reg_addr == `OCS_WINDOW_OFFSET)) begin
         window_ff <= reg_wdata;                                  // [R6]
      end
   end

   // sticky per-port flags, write one to clear, set wins
   assign flag_set = chan_event[`OCS_NUM_PORTS-1:0]
                   | {`OCS_NUM_PORTS{chan_event[`OCS_SHARED_CHAN]}};   // [R16]
   assign flag_clr = (reg_wr && (reg_addr == `OCS_STATUS_OFFSET))
                   ? reg_wdata[`OCS_NUM_PORTS-1:0] : {`OCS_NUM_PORTS{1'b0}};

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         flag_ff <= {`OCS_NUM_PORTS{1'b0}};
      end else begin
         flag_ff <= (flag_ff & ~flag_clr) | flag_set;             // [R19]
      end
   end

   assign ocs_flag = flag_ff;

   // read data, one cycle after the read strobe
   always_comb begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `OCS_LOCKOUT_OFFSET:   nxt_rdata = lockout_ff;
         `OCS_MIN_WIDTH_OFFSET: nxt_rdata = {4'h0, min_width_ff}; // [R4]
         `OCS_WINDOW_OFFSET:    nxt_rdata = window_ff;
         `OCS_STATUS_OFFSET:    nxt_rdata = {2'h0, flag_ff};
         default:               nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // checks
   a_drive_low_off : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R11]
      (!port_power_en[0] && !gang_mode) |=> (port_power_sense_pin_oe[0] && !port_pullup_en[0]))
      else $error("unpowered port pin not driven low");

   a_pullup_on : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R12]
      (port_power_en[0] && !gang_mode) |=> (!port_power_sense_pin_oe[0] && port_pullup_en[0]))
      else $error("powered port pin not released with pull-up");

   a_min_width_rst : assert property (@(posedge clk) // [R5]
      $rose(rst_n_sync) |-> (min_width_ff == 4'h5))
      else $error("min width reset value wrong");

   a_window_rst : assert property (@(posedge clk) // [R7]
      $rose(rst_n_sync) |-> (window_ff == 8'h14))
      else $error("double pulse window reset value wrong");

   a_lockout_rst : assert property (@(posedge clk) // [R10]
      $rose(rst_n_sync) |-> (lockout_ff == 8'h0a))
      else $error("lockout reset value wrong");

   a_gang_all_ports : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R16]
      chan_event[`OCS_SHARED_CHAN] |=> (&flag_ff))
      else $error("shared overcurrent did not flag every port");

   a_flag_sticky : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R19]
      (flag_ff[0] && !flag_clr[0]) |=> flag_ff[0])
      else $error("overcurrent flag dropped without clear");

   a_set_over_clear : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R19]
      (flag_set[0] && flag_clr[0]) |=> flag_ff[0])
      else $error("flag lost when set and clear collide");

   a_reserved_zero : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R4]
      (reg_rd && (reg_addr == `OCS_MIN_WIDTH_OFFSET)) |=> (reg_rdata[7:4] == 4'h0))
      else $error("reserved min width bits read nonzero");

   a_tick_spacing : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R18]
      (tick_ff && (TICK_CYCLES > 1)) |=> !tick_ff)
      else $error("ms tick asserted on adjacent cycles");

   a_tick_restart : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R18]
      tick_ff |-> (tick_cnt_ff == 17'h00000))
      else $error("ms tick not aligned with counter restart");

   // pin drive checks
   a_shared_off_low : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R11]
      !gang_power |=> (shared_power_sense_pin_oe && !shared_pullup_en))
      else $error("unpowered shared pin not driven low");

   a_shared_on_pullup : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R12]
      gang_power |=> (!shared_power_sense_pin_oe && shared_pullup_en))
      else $error("powered shared pin not released with pull-up");

   a_gang_ports_low : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R16]
      gang_mode |=> (&port_power_sense_pin_oe))
      else $error("port pin left released in ganged mode");

   a_oe_pullup_excl : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R12]
      !(|(port_power_sense_pin_oe & port_pullup_en)))
      else $error("pull-up enabled while pin driven low");

   // register checks
   a_window_write : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R6]
      (reg_wr && (reg_addr == `OCS_WINDOW_OFFSET)) |=> (window_ff == $past(reg_wdata)))
      else $error("double pulse window write lost");

   a_window_read : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R7]
      (reg_rd && (reg_addr == `OCS_WINDOW_OFFSET)) |=> (reg_rdata == $past(window_ff)))
      else $error("double pulse window readback wrong");

   a_lockout_write : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R10]
      (reg_wr && (reg_addr == `OCS_LOCKOUT_OFFSET)) |=> (lockout_ff == $past(reg_wdata)))
      else $error("lockout write lost");

   a_min_width_write : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R4]
      (reg_wr && (reg_addr == `OCS_MIN_WIDTH_OFFSET)) |=> ({4'h0, min_width_ff} == ($past(reg_wdata) & 8'h0f)))
      else $error("min width write lost");

   a_status_read : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R19]
      (reg_rd && (reg_addr == `OCS_STATUS_OFFSET)) |=> (reg_rdata == {2'h0, $past(flag_ff)}))
      else $error("status readback does not match flags");

   // flag and event checks
   a_flag_clear : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R19]
      (flag_clr[0] && !flag_set[0]) |=> !flag_ff[0])
      else $error("overcurrent flag not cleared");

   a_flag_needs_event : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R19]
      (!flag_ff[0] && !flag_set[0]) |=> !flag_ff[0])
      else $error("overcurrent flag set without event");

   a_event_needs_low : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R13]
      chan_event[0] |-> !$past(pin_sync_ff[0]))
      else $error("overcurrent event without low pin");

   a_event_needs_power : assert property (@(posedge clk) disable iff (!rst_n_sync) // [R1]
      chan_event[0] |-> $past(chan_power[0], 2))
      else $error("overcurrent event on unpowered port");

   c_single_port : cover property (@(posedge clk) disable iff (!rst_n_sync)
      !gang_mode && chan_event[0]);

   c_gang_event : cover property (@(posedge clk) disable iff (!rst_n_sync)
      gang_mode && chan_event[`OCS_SHARED_CHAN]);

   c_flag_cleared : cover property (@(posedge clk) disable iff (!rst_n_sync)
      flag_ff[0] ##1 !flag_ff[0]);

   c_gang_all_flagged : cover property (@(posedge clk) disable iff (!rst_n_sync)
      gang_mode && (&flag_ff));

   c_status_read : cover property (@(posedge clk) disable iff (!rst_n_sync)
      reg_rd && (reg_addr == `OCS_STATUS_OFFSET) && (|flag_ff));

endmodule : port_overcurrent_detect

// ==== test/ocs_switch_model.sv ====
// behavioural external power switch or poly fuse seen on open-drain control/sense pins
`timescale 1ns/1ps
module ocs_switch_model #(
   parameter int N = 1
) (
   input  wire logic         clk,
   input  wire logic [N-1:0] oe,
   input  wire logic [N-1:0] pu_en,
   input  wire logic [N-1:0] fault,
   output logic      [N-1:0] pin
);
   logic [N-1:0] drift_ff = '0;

   // undriven pin without pull-up wanders
   always_ff @(posedge clk) begin
      drift_ff <= ~drift_ff;
   end

   // fault pulls the open-drain line low; driven low when powered off
   // pin follows power at once: no power-good delay
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin[i] = oe[i] ? 1'b0 : (fault[i] ? 1'b0 : (pu_en[i] ? 1'b1 : drift_ff[i]));
      end
   end
endmodule : ocs_switch_model

// ==== test/tb_port_overcurrent_detect.sv ====
// self-checking bench for per-port power control and overcurrent flags
`timescale 1ns/1ps
`include "ocs_regs.svh"
module tb_port_overcurrent_detect;
   import ocs_pkg::*;
   logic        clk;
   logic        reset_n;
   logic        gang_mode;
   logic        reg_wr;
   logic        reg_rd;
   logic        sh_fault;
   logic [5:0]  power_en;
   logic [5:0]  fault;
   logic [5:0]  pin_i;
   logic [5:0]  pin_oe;
   logic [5:0]  port_pu;
   logic [5:0]  pin_o;
   logic        sh_o;
   logic [5:0]  ocs_flag;
   logic        sh_i;
   logic        sh_oe;
   logic        sh_pu;
   logic [15:0] reg_addr;
   reg_byte_t   reg_wdata;
   reg_byte_t   reg_rdata;
   int          n_mismatch = 0;
   int          compares = 0;

   port_overcurrent_detect #(.TICK_CYCLES(20)) dut (
      .clk(clk), .reset_n(reset_n), .port_power_en(power_en), .gang_mode(gang_mode),
      .port_power_sense_pin_i(pin_i), .port_power_sense_pin_o(pin_o), .port_power_sense_pin_oe(pin_oe),
      .port_pullup_en(port_pu), .shared_power_sense_pin_i(sh_i), .shared_power_sense_pin_o(sh_o),
      .shared_power_sense_pin_oe(sh_oe), .shared_pullup_en(sh_pu), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ocs_flag(ocs_flag));

   ocs_switch_model #(.N(6)) ports (.clk(clk), .oe(pin_oe), .pu_en(port_pu), .fault(fault), .pin(pin_i));
   ocs_switch_model #(.N(1)) shared (.clk(clk), .oe(sh_oe), .pu_en(sh_pu), .fault(sh_fault), .pin(sh_i));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic conclude();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [15:0] a, input reg_byte_t d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input string what, input logic [15:0] a, input reg_byte_t exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
      chk(what, exp, reg_rdata);
   endtask : rd_chk

   task automatic pulse(input int p, input int n);
      @(posedge clk);
      fault[p] <= 1'b1;
      cyc(n);
      fault[p] <= 1'b0;
   endtask : pulse

   task automatic flags(input logic [5:0] exp);
      @(posedge clk);
      #1;
      chk("flags", {2'b00, exp}, {2'b00, ocs_flag});
   endtask : flags

   initial begin
      reset_n = 1'b0;
      gang_mode = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sh_fault = 1'b0;
      power_en = 6'h00;
      fault = 6'h00;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      cyc(16);
      reset_n <= 1'b1;
      cyc(3);
      rd_chk("lockout", `OCS_LOCKOUT_OFFSET, 8'h0a);
      rd_chk("min width", `OCS_MIN_WIDTH_OFFSET, 8'h05);
      rd_chk("window", `OCS_WINDOW_OFFSET, 8'h14);
      wr(`OCS_MIN_WIDTH_OFFSET, 8'hf3);
      rd_chk("min width", `OCS_MIN_WIDTH_OFFSET, 8'h03);
      wr(16'h30e2, 8'h5a);
      rd_chk("unmapped", 16'h30e2, 8'h00);
      wr(`OCS_WINDOW_OFFSET, 8'h3c);
      rd_chk("window", `OCS_WINDOW_OFFSET, 8'h3c);
      wr(`OCS_LOCKOUT_OFFSET, 8'h03);
      #1;
      chk("oe", 8'h3f, {2'b00, pin_oe});
      chk("pullup", 8'h00, {2'b00, port_pu});
      chk("pin out", 8'h00, {2'b00, pin_o});
      chk("shared oe", 8'h01, {7'h00, sh_oe});
      chk("shared pullup", 8'h00, {7'h00, sh_pu});
      @(posedge clk);
      power_en <= 6'h1f;
      cyc(2);
      #1;
      chk("oe", 8'h20, {2'b00, pin_oe});
      chk("pullup", 8'h1f, {2'b00, port_pu});
      cyc(100);
      // one long low on port 0
      pulse(0, 90);
      cyc(6);
      flags(6'h01);
      cyc(40);
      flags(6'h01);
      rd_chk("status", `OCS_STATUS_OFFSET, 8'h01);
      wr(`OCS_STATUS_OFFSET, 8'h01);
      flags(6'h00);
      // two short lows on port 1 inside the window
      wr(`OCS_MIN_WIDTH_OFFSET, 8'h05);
      pulse(1, 5);
      cyc(30);
      flags(6'h00);
      pulse(1, 5);
      cyc(8);
      flags(6'h02);
      wr(`OCS_STATUS_OFFSET, 8'h02);
      // two short lows on port 2 further apart than a 1 ms window
      wr(`OCS_WINDOW_OFFSET, 8'h01);
      pulse(2, 5);
      cyc(100);
      pulse(2, 5);
      cyc(8);
      flags(6'h00);
      // lows during power-on lockout of port 4 are not counted
      wr(`OCS_WINDOW_OFFSET, 8'h14);
      @(posedge clk);
      power_en[4] <= 1'b0;
      cyc(5);
      power_en[4] <= 1'b1;
      fault[4] <= 1'b1;
      cyc(15);
      fault[4] <= 1'b0;
      cyc(100);
      pulse(4, 5);
      cyc(8);
      flags(6'h00);
      pulse(4, 5);
      cyc(8);
      flags(6'h10);
      wr(`OCS_STATUS_OFFSET, 8'h10);
      flags(6'h00);
      // ganged mode over the shared pin
      @(posedge clk);
      gang_mode <= 1'b1;
      power_en <= 6'h3f;
      cyc(2);
      #1;
      chk("oe", 8'h3f, {2'b00, pin_oe});
      chk("shared oe", 8'h00, {7'h00, sh_oe});
      chk("shared pullup", 8'h01, {7'h00, sh_pu});
      chk("shared out", 8'h00, {7'h00, sh_o});
      chk("pin out", 8'h00, {2'b00, pin_o});
      cyc(100);
      sh_fault <= 1'b1;
      cyc(140);
      sh_fault <= 1'b0;
      cyc(6);
      flags(6'h3f);
      conclude();
   end

   initial begin
      cyc(5000);
      n_mismatch++;
      conclude();
   end
endmodule : tb_port_overcurrent_detect
